// >>> hdl/ssd_decode.v
`timescale 1ns/1ns
`include "ssd_map.vh"
module ssd_decode (
	input  wire       ref_clk,
	input  wire       nrst,
	input  wire       req,
	input  wire [1:0] mode,
	input  wire       we,
	input  wire       bit_op,
	input  wire [2:0] bit_sel,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	output reg        ack,
	output reg        err,
	output wire [7:0] rdata,
	output reg  [7:0] stack_top_pointer,
	output wire       sr_req,
	output wire       sr_we,
	output wire [7:0] sr_addr,
	output wire [7:0] sr_wdata,
	input  wire [7:0] sr_rdata
);
	////////////////////////////////////////////////////////////////////////
	function is_sr;
		input [7:0] a;
		begin
			is_sr = (a >= `SSD_SR_LO);
		end
	endfunction

	function is_bit_ok;
		input [7:0] a;
		begin
			is_bit_ok = (a[3:0] == `SSD_BIT_NIB0) || (a[3:0] == `SSD_BIT_NIB8);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	wire       is_push;
	wire       is_pop;
	wire       to_sr;
	wire       to_stp;
	wire       bit_bad;
	wire [7:0] push_addr;
	wire [7:0] ram_addr;
	wire       ram_wr;
	wire       ram_rd;
	wire [7:0] ram_rdata;
	wire [7:0] byte_old;
	wire [7:0] byte_new;
	wire [7:0] bit_mask;
	reg        rd_from_ram;
	reg        rd_is_bit;
	reg  [2:0] rd_bit;
	reg  [7:0] sr_hold;
	reg  [7:0] next_sp;

	assign is_push   = req && (mode == `SSD_MODE_PUSH);
	assign is_pop    = req && (mode == `SSD_MODE_POP);
	assign push_addr = stack_top_pointer + 8'h01;
	// only direct mode above 0x7f reaches special space
	assign to_sr     = req && (mode == `SSD_MODE_DIRECT) && is_sr(addr);
	assign to_stp    = to_sr && (addr == `SSD_STP_ADDR);
	assign bit_bad   = to_sr && bit_op && !is_bit_ok(addr);
	assign ram_addr  = is_push ? push_addr : (is_pop ? stack_top_pointer : addr);
	assign bit_mask  = 8'h01 << bit_sel;
	assign byte_old  = to_sr ? (to_stp ? stack_top_pointer : sr_rdata) : ram_rdata;
	// bit write: merge one bit into the current byte
	assign byte_new  = bit_op ? ((byte_old & ~bit_mask) | (wdata[0] ? bit_mask : 8'h00))
		: wdata;

	// ram writes on push, or byte writes to ram addresses
	assign ram_wr = is_push || (req && !to_sr && we && !bit_op
		&& (mode != `SSD_MODE_POP));
	assign ram_rd = req && !to_sr;

	// special register port; stack top pointer served locally
	assign sr_req   = to_sr && !to_stp && !bit_bad;
	assign sr_we    = sr_req && we;
	assign sr_addr  = addr;
	assign sr_wdata = byte_new;

	ssd_ram u_ram (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.wr_en   (ram_wr),
		.wr_addr (ram_addr),
		.wr_data (is_push ? wdata : byte_new),
		.rd_en   (ram_rd),
		.rd_addr (ram_addr),
		.rd_data (ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	always @* begin
		next_sp = stack_top_pointer;
		if (is_push)
			next_sp = push_addr;
		else if (is_pop)
			next_sp = stack_top_pointer - 8'h01;
		else if (to_stp && we && !bit_op)
			next_sp = wdata;
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stack_top_pointer <= `SSD_STP_RESET;
			ack               <= 1'b0;
			err               <= 1'b0;
			rd_from_ram       <= 1'b0;
			rd_is_bit         <= 1'b0;
			rd_bit            <= 3'h0;
			sr_hold           <= 8'h00;
		end else begin
			stack_top_pointer <= next_sp;
			ack               <= req;
			err               <= bit_bad;
			rd_from_ram       <= ram_rd;
			rd_is_bit         <= bit_op && !is_push && !is_pop;
			rd_bit            <= bit_sel;
			if (to_sr)
				sr_hold <= bit_bad ? 8'h00 : (to_stp ? stack_top_pointer : sr_rdata);
		end
	end

	// pop returns the byte at the old pointer
	wire [7:0] byte_rd;
	assign byte_rd = rd_from_ram ? ram_rdata : sr_hold;
	assign rdata   = rd_is_bit ? {7'h00, byte_rd[rd_bit]} : byte_rd;
endmodule // ssd_decode

// >>> hdl/ssd_map.vh
`ifndef SSD_MAP_VH
`define SSD_MAP_VH
// stack top pointer location and reset value
`define SSD_STP_ADDR      8'h81
`define SSD_STP_RESET     8'h07
// special register space window
`define SSD_SR_LO         8'h80
// bit-addressable low nibbles
`define SSD_BIT_NIB0      4'h0
`define SSD_BIT_NIB8      4'h8
// access modes
`define SSD_MODE_DIRECT   2'h0
`define SSD_MODE_INDIRECT 2'h1
`define SSD_MODE_PUSH     2'h2
`define SSD_MODE_POP      2'h3
// data memory depth
`define SSD_RAM_DEPTH     256
`endif

// >>> hdl/ssd_ram.v
`timescale 1ns/1ns
// 256 x 8 data memory in flip-flops, synchronous write, registered read
module ssd_ram (
	input  wire       ref_clk,
	input  wire       nrst,
	input  wire       wr_en,
	input  wire [7:0] wr_addr,
	input  wire [7:0] wr_data,
	input  wire       rd_en,
	input  wire [7:0] rd_addr,
	output reg  [7:0] rd_data
);
	reg [7:0] mem [0:255];
	integer i;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (i = 0; i < 256; i = i + 1)
				mem[i] <= 8'h00;
			rd_data <= 8'h00;
		end else begin
			if (wr_en)
				mem[wr_addr] <= wr_data;
			if (rd_en)
				rd_data <= mem[rd_addr];
		end
	end
endmodule // ssd_ram

// >>> bench/ssd_sr_model.sv
`timescale 1ns/1ns
module ssd_sr_model (
	input  wire  ref_clk,
	input  wire  sr_req,
	input  wire  sr_we,
	input  wire  [7:0] sr_addr,
	input  wire  [7:0] sr_wdata,
	output logic [7:0] sr_rdata
);
	logic [7:0] m [0:255];
	always @(posedge ref_clk) if (sr_req && sr_we) m[sr_addr] <= sr_wdata;
	// unselected: inverse of stored byte; only occupied addresses used
	assign sr_rdata = sr_req ? m[sr_addr] : ~m[sr_addr];
endmodule // ssd_sr_model

// >>> bench/ssd_decode_chk.sv
`timescale 1ns/1ns
module ssd_decode_chk (
	input wire       ref_clk,
	input wire       nrst,
	input wire       req,
	input wire [1:0] mode,
	input wire       we,
	input wire       bit_op,
	input wire [7:0] addr,
	input wire       ack,
	input wire       err,
	input wire [7:0] rdata,
	input wire [7:0] stack_top_pointer,
	input wire       sr_req
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire dbit = req && mode == 2'h0 && bit_op && addr[7];
	wire push = req && mode == 2'h2;
	wire pop = req && mode == 2'h3;
	a_ack_one: assert property (req |=> ack) else $error("ack missing");
	a_push_step: assert property (push |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
		else $error("push step");
	a_pop_step: assert property (pop |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01)
		else $error("pop step");
	a_reset_ptr: assert property ($rose(nrst) |-> stack_top_pointer == 8'h07) else $error("reset");
	a_ptr_read: assert property (req && mode == 2'h0 && !we && !bit_op && addr == 8'h81
		|=> rdata == $past(stack_top_pointer)) else $error("ptr read");
	a_bit_refuse: assert property (dbit && addr[2:0] != 3'h0 |=> err) else $error("refuse");
	a_bit_allow: assert property (dbit && addr[2:0] == 3'h0 |=> !err) else $error("allow");
	a_direct_sr: assert property (req && mode == 2'h0 && addr[7] && !bit_op && addr != 8'h81
		|-> sr_req) else $error("direct");
	a_ind_ram: assert property (req && mode != 2'h0 |-> !sr_req) else $error("indirect");
	c_push: cover property (push);
	c_pop: cover property (pop);
	c_refuse: cover property (err);
endmodule // ssd_decode_chk
bind ssd_decode ssd_decode_chk ssd_decode_chk_i (.ref_clk, .nrst, .req, .mode, .we, .bit_op, .addr,
	.ack, .err, .rdata, .stack_top_pointer, .sr_req);

// >>> bench/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic ref_clk, nrst, req, we, bit_op, ack, err, sr_req, sr_we;
	logic [1:0] mode;
	logic [2:0] bit_sel;
	logic [7:0] addr, wdata, rdata, stack_top_pointer, sr_addr, sr_wdata, sr_rdata;
	int n_fail = 0;
	int n_tests = 0;
	ssd_decode ssd_decode_i (.ref_clk, .nrst, .req, .mode, .we, .bit_op, .bit_sel, .addr, .wdata,
		.ack, .err, .rdata, .stack_top_pointer, .sr_req, .sr_we, .sr_addr, .sr_wdata, .sr_rdata);
	ssd_sr_model ssd_sr_model_i (.ref_clk, .sr_req, .sr_we, .sr_addr, .sr_wdata, .sr_rdata);
	task chk(input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// c = {mode, we, bit_op}; bit index from d[6:4], bit value d[0]
	task acc(input logic [3:0] c, input logic [7:0] a, d);
		@(negedge ref_clk);
		{req, mode, we, bit_op, bit_sel, addr, wdata} = {1'b1, c, d[6:4], a, d};
		@(negedge ref_clk);
		req = 1'b0;
		chk({7'h00, ack}, 8'h01);
	endtask
	task tally_and_finish;
		if (n_fail == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#20000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		{nrst, req, mode, we, bit_op, bit_sel, addr, wdata} = 24'h000000;
		repeat (6) @(negedge ref_clk);
		nrst = 1'b1;
		chk(stack_top_pointer, 8'h07);
		acc(4'h0, 8'h81, 8'h00);
		chk(rdata, 8'h07);
		acc(4'h8, 8'h00, 8'haa);
		chk(stack_top_pointer, 8'h08);
		acc(4'h4, 8'h08, 8'h00);
		chk(rdata, 8'haa);
		acc(4'h8, 8'h00, 8'h55);
		acc(4'hc, 8'h00, 8'h00);
		chk(rdata, 8'h55);
		chk(stack_top_pointer, 8'h08);
		acc(4'h2, 8'h81, 8'hff);
		acc(4'h8, 8'h00, 8'h11);
		chk(stack_top_pointer, 8'h00);
		acc(4'hc, 8'h00, 8'h00);
		chk(rdata, 8'h11);
		chk(stack_top_pointer, 8'hff);
		acc(4'h2, 8'h90, 8'ha5);
		acc(4'h6, 8'h90, 8'h3c);
		acc(4'h0, 8'h90, 8'h00);
		chk(rdata, 8'ha5);
		acc(4'h4, 8'h90, 8'h3c);
		chk(rdata, 8'h3c);
		acc(4'h3, 8'h90, 8'h20);
		acc(4'h0, 8'h90, 8'h00);
		chk(rdata, 8'ha1);
		acc(4'h1, 8'h90, 8'h50);
		chk(rdata, 8'h01);
		acc(4'h3, 8'h89, 8'h01);
		chk({7'h00, err}, 8'h01);
		acc(4'h8, 8'h00, 8'h33);
		@(negedge ref_clk);
		nrst = 1'b0;
		@(negedge ref_clk);
		nrst = 1'b1;
		chk(stack_top_pointer, 8'h07);
		tally_and_finish();
	end
endmodule // testbench
